// ===== core/hbs_pkg.sv
// Purpose: shared constants and types for the host bus port and its partner
// Assumes: one clock, synchronous active-high reset, active-low pins except snoop_ctl0
// Notes:   timing counts are in host bus clocks
package hbs_pkg;
  localparam int          HBS_ADDR_W      = 7;
  localparam int          HBS_DATA_W      = 32;
  localparam int          HBS_SIZE_W      = 2;
  localparam int          HBS_WAIT_CLKS   = 3;
  localparam logic [1:0]  HBS_WAIT_LAST   = 2'h2;
  localparam int          HBS_FAST_ARB_BIT = 1;
  localparam int          HBS_SNOOP_BIT   = 0;
  localparam logic        HBS_PIN_IDLE    = 1'b1;
  typedef enum logic [1:0] {HBS_OP_READ, HBS_OP_WRITE} hbs_op_t;
endpackage

// ===== core/hbs_if.sv
// Purpose: processor bus wires between the device port and the host side
// Assumes: active-low control pins except the active-high snoop_ctl0, the device drives data only when enabled
// Notes:   the data wire level is resolved here from the two enables
`timescale 1ns/1ps
interface hbs_if;
  logic                          rw_n;
  logic [hbs_pkg::HBS_ADDR_W-1:0] addr;
  logic [hbs_pkg::HBS_SIZE_W-1:0] transfer_size;
  logic                          transfer_start_n;
  logic                          chip_select_n;
  logic                          transfer_ack_n;
  logic                          burst_inhibit_n;
  logic                          burst_inhibit_oe_n;
  logic                          slave_ack_n;
  logic                          transfer_error_ack_n;
  logic                          transfer_error_ack_oe_n;
  logic [hbs_pkg::HBS_DATA_W-1:0] dev_data_out;
  logic                          dev_data_oe_n;
  logic [hbs_pkg::HBS_DATA_W-1:0] host_data_out;
  logic                          host_data_oe_n;
  logic [hbs_pkg::HBS_DATA_W-1:0] data;
  logic                          bus_request_n;
  logic                          bus_grant_n;
  logic                          bus_busy_out_n;
  logic                          bus_busy_oe_n;
  logic                          bus_busy_host_n;
  logic                          bus_busy_n;
  logic                          master_n;
  logic                          fetch_n;
  logic                          snoop_ctl0;

  assign data       = !dev_data_oe_n ? dev_data_out :
                      (!host_data_oe_n ? host_data_out : '0);
  assign bus_busy_n = (bus_busy_oe_n || bus_busy_out_n) && bus_busy_host_n;

  modport device (
    input  rw_n, addr, transfer_size, transfer_start_n, chip_select_n,
    input  transfer_ack_n, data, bus_grant_n, bus_busy_n, snoop_ctl0,
    output burst_inhibit_n, burst_inhibit_oe_n, slave_ack_n, transfer_error_ack_n,
    output transfer_error_ack_oe_n, dev_data_out, dev_data_oe_n,
    output bus_request_n, bus_busy_out_n, bus_busy_oe_n, master_n, fetch_n
  );
  modport host (
    output rw_n, addr, transfer_size, transfer_start_n, chip_select_n,
    output transfer_ack_n, host_data_out, host_data_oe_n, bus_grant_n,
    output bus_busy_host_n, snoop_ctl0,
    input  burst_inhibit_n, burst_inhibit_oe_n, slave_ack_n, transfer_error_ack_n,
    input  transfer_error_ack_oe_n, data, bus_request_n, bus_busy_n, master_n,
    input  fetch_n
  );
endinterface

// ===== core/hbs_device.sv
// Purpose: device end: register slave cycles and bus mastership handshake
// Assumes: all pins synchronous to clock; registers live in the user logic
// Notes:   user side sees a one-cycle access pulse and answers with rd_data/err
`timescale 1ns/1ps

// What this block does
// - host presents cycle; device qualifies chip select
// - burst inhibit asserted after chip select qualified
// - host drops transfer start before wait end
// - read inserts three waits then drives data
// - write data after start; three waits
// - slave acknowledge when no error
// - error gives only error acknowledge, ends next
// - wait for transfer acknowledge before ending
// - negate slave or error acknowledge at close
// - release data, inhibit, error drivers at end
// - request bus when needed; fetch indicator
// - on grant with busy free, own bus
// - sample grant and busy after request
// - fast arbitration acknowledges grant immediately
// - interrupt during request: await grant, drop, interrupt
// - snoop mode: request 1-2 clocks after snoop
// - request 1-2 clocks after fetch indicator
// - drop fetch 1-2 clocks after releasing busy
// - retry keeps fetch until success or fatal
// - fast mode owns on grant regardless
module hbs_device
  import hbs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // processor bus
  hbs_if.device                      bus,
  // register side
  output logic                       reg_access,
  output logic                       reg_write,
  output logic [HBS_ADDR_W-1:0]      reg_addr,
  output logic [HBS_SIZE_W-1:0]      reg_size,
  output logic [HBS_DATA_W-1:0]      reg_wdata,
  input  wire logic [HBS_DATA_W-1:0] reg_rdata,
  input  wire logic                  reg_error,
  // mastership side
  input  wire logic                  need_bus,
  input  wire logic                  need_fetch,
  input  wire logic                  fetch_retry,
  input  wire logic                  master_done,
  input  wire logic                  scsi_irq,
  input  wire logic                  fast_arb,
  input  wire logic                  snoop_mode,
  output logic                       owner,
  output logic                       irq
);
  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_ACK, S_ERR, S_CLOSE} hbs_slv_t;
  typedef enum logic [2:0] {M_IDLE, M_PRE, M_REQ, M_OWN, M_ABORT} hbs_mst_t;

  hbs_slv_t slv_reg, slv_next;
  hbs_mst_t mst_reg, mst_next;
  logic [1:0] wait_reg;
  logic       fetch_hold_reg;
  logic       fetch_drop_reg;
  logic       irq_pend_reg;

  wire sel_hit   = !bus.transfer_start_n && !bus.chip_select_n;
  wire wait_done = (wait_reg == HBS_WAIT_LAST);
  wire ta_seen   = !bus.transfer_ack_n;
  wire grant_ok  = !bus.bus_grant_n && (fast_arb || bus.bus_busy_n);
  wire snoop_req = snoop_mode && bus.snoop_ctl0;

  always_comb begin
    slv_next = slv_reg;
    unique case (slv_reg)
      S_IDLE:  if (sel_hit) slv_next = S_WAIT;
      S_WAIT:  if (wait_done) slv_next = reg_error ? S_ERR : S_ACK;
      S_ACK:   if (ta_seen) slv_next = S_CLOSE;
      S_ERR:   slv_next = S_CLOSE;
      S_CLOSE: slv_next = S_IDLE;
    endcase
  end

  always_comb begin
    mst_next = mst_reg;
    unique case (mst_reg)
      M_IDLE:  if (need_bus || snoop_req) mst_next = M_PRE;
      M_PRE:   mst_next = M_REQ;
      M_REQ:   if (grant_ok) mst_next = irq_pend_reg || scsi_irq ? M_ABORT : M_OWN;
      M_OWN:   if (master_done) mst_next = M_IDLE;
      M_ABORT: mst_next = M_IDLE;
    endcase
  end

  // slave cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      slv_reg                      <= S_IDLE;
      wait_reg                     <= 2'h0;
      bus.burst_inhibit_n          <= HBS_PIN_IDLE;
      bus.burst_inhibit_oe_n       <= HBS_PIN_IDLE;
      bus.slave_ack_n              <= HBS_PIN_IDLE;
      bus.transfer_error_ack_n     <= HBS_PIN_IDLE;
      bus.transfer_error_ack_oe_n  <= HBS_PIN_IDLE;
      bus.dev_data_out             <= '0;
      bus.dev_data_oe_n            <= HBS_PIN_IDLE;
      reg_access                   <= 1'b0;
      reg_write                    <= 1'b0;
      reg_addr                     <= '0;
      reg_size                     <= '0;
      reg_wdata                    <= '0;
    end else if (clk_en) begin
      slv_reg    <= slv_next;
      reg_access <= 1'b0;
      if (slv_reg == S_IDLE && sel_hit) begin
        bus.burst_inhibit_n     <= 1'b0;
        bus.burst_inhibit_oe_n  <= 1'b0;
        bus.transfer_error_ack_oe_n <= 1'b0;
        reg_write <= bus.rw_n == 1'b0;
        reg_addr  <= bus.addr;
        reg_size  <= bus.transfer_size;
        wait_reg  <= 2'h0;
      end
      if (slv_reg == S_WAIT) begin
        wait_reg <= wait_reg + 2'h1;
        if (wait_done) begin
          reg_access <= 1'b1;
          reg_wdata  <= bus.data;
          bus.slave_ack_n          <= reg_error;
          bus.transfer_error_ack_n <= !reg_error;
          if (reg_write == 1'b0 && !reg_error) begin
            bus.dev_data_out  <= reg_rdata;
            bus.dev_data_oe_n <= 1'b0;
          end
        end
      end
      if ((slv_reg == S_ACK && ta_seen) || slv_reg == S_ERR) begin
        bus.slave_ack_n          <= HBS_PIN_IDLE;
        bus.transfer_error_ack_n <= HBS_PIN_IDLE;
      end
      if (slv_reg == S_CLOSE) begin
        bus.dev_data_oe_n           <= HBS_PIN_IDLE;
        bus.burst_inhibit_n         <= HBS_PIN_IDLE;
        bus.burst_inhibit_oe_n      <= HBS_PIN_IDLE;
        bus.transfer_error_ack_oe_n <= HBS_PIN_IDLE;
      end
    end
  end

  // mastership
  always_ff @(posedge clock) begin
    if (reset) begin
      mst_reg            <= M_IDLE;
      bus.bus_request_n  <= HBS_PIN_IDLE;
      bus.bus_busy_out_n <= HBS_PIN_IDLE;
      bus.bus_busy_oe_n  <= HBS_PIN_IDLE;
      bus.master_n       <= HBS_PIN_IDLE;
      bus.fetch_n        <= HBS_PIN_IDLE;
      fetch_hold_reg     <= 1'b0;
      fetch_drop_reg     <= 1'b0;
      irq_pend_reg       <= 1'b0;
      owner              <= 1'b0;
      irq                <= 1'b0;
    end else if (clk_en) begin
      mst_reg <= mst_next;
      irq     <= 1'b0;
      // drop comes first so a fetch raised on the same edge is kept
      if (fetch_drop_reg) begin
        bus.fetch_n    <= HBS_PIN_IDLE;
        fetch_hold_reg <= 1'b0;
        fetch_drop_reg <= 1'b0;
      end
      if (mst_reg == M_IDLE && need_bus && need_fetch) begin
        bus.fetch_n    <= 1'b0;
        fetch_hold_reg <= 1'b1;
      end
      if (mst_reg == M_PRE)
        bus.bus_request_n <= 1'b0;
      if (mst_reg != M_IDLE && scsi_irq)
        irq_pend_reg <= 1'b1;
      if (mst_reg == M_REQ && grant_ok) begin
        bus.bus_request_n  <= HBS_PIN_IDLE;
        bus.bus_busy_out_n <= 1'b0;
        bus.bus_busy_oe_n  <= 1'b0;
        bus.master_n       <= 1'b0;
        owner <= !(irq_pend_reg || scsi_irq);
      end
      if ((mst_reg == M_OWN && master_done) || mst_reg == M_ABORT) begin
        bus.bus_busy_out_n <= HBS_PIN_IDLE;
        bus.bus_busy_oe_n  <= HBS_PIN_IDLE;
        bus.master_n       <= HBS_PIN_IDLE;
        owner              <= 1'b0;
        fetch_drop_reg     <= fetch_hold_reg && !fetch_retry;
      end
      if (mst_reg == M_ABORT) begin
        irq          <= 1'b1;
        irq_pend_reg <= 1'b0;
      end
    end
  end
endmodule

// ===== core/hbs_host.sv
// Purpose: host end: issues register cycles and grants the bus
// Assumes: one outstanding access; arbiter grants whenever requested
// Notes:   answers on reg_done with read data and error flag
`timescale 1ns/1ps
module hbs_host
  import hbs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // processor bus
  hbs_if.host                        bus,
  // command side
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_write,
  input  wire logic [HBS_ADDR_W-1:0] cmd_addr,
  input  wire logic [HBS_SIZE_W-1:0] cmd_size,
  input  wire logic [HBS_DATA_W-1:0] cmd_wdata,
  input  wire logic                  snoop,
  output logic                       cmd_busy,
  output logic                       reg_done,
  output logic                       reg_err,
  output logic [HBS_DATA_W-1:0]      reg_rdata
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_WAIT, H_ACK} hbs_hst_t;
  hbs_hst_t st_reg;

  wire dev_ack = !bus.slave_ack_n;
  wire dev_err = !bus.transfer_error_ack_n && !bus.transfer_error_ack_oe_n;

  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg              <= H_IDLE;
      bus.rw_n            <= HBS_PIN_IDLE;
      bus.addr            <= '0;
      bus.transfer_size   <= '0;
      bus.transfer_start_n <= HBS_PIN_IDLE;
      bus.chip_select_n   <= HBS_PIN_IDLE;
      bus.transfer_ack_n  <= HBS_PIN_IDLE;
      bus.host_data_out   <= '0;
      bus.host_data_oe_n  <= HBS_PIN_IDLE;
      bus.bus_grant_n     <= HBS_PIN_IDLE;
      bus.bus_busy_host_n <= HBS_PIN_IDLE;
      bus.snoop_ctl0      <= 1'b0;
      cmd_busy            <= 1'b0;
      reg_done            <= 1'b0;
      reg_err             <= 1'b0;
      reg_rdata           <= '0;
    end else if (clk_en) begin
      reg_done       <= 1'b0;
      bus.snoop_ctl0 <= snoop;
      // arbiter grants while requested, withdraws one clock after the request is released
      bus.bus_grant_n <= bus.bus_request_n;
      unique case (st_reg)
        H_IDLE: if (cmd_valid) begin
          st_reg               <= H_START;
          cmd_busy             <= 1'b1;
          bus.rw_n             <= !cmd_write;
          bus.addr             <= cmd_addr;
          bus.transfer_size    <= cmd_size;
          bus.transfer_start_n <= 1'b0;
          bus.chip_select_n    <= 1'b0;
          bus.host_data_out    <= cmd_wdata;
          // the host owns the bus for its own register cycle
          bus.bus_busy_host_n  <= 1'b0;
        end
        H_START: begin
          st_reg               <= H_WAIT;
          bus.transfer_start_n <= HBS_PIN_IDLE;
          bus.host_data_oe_n   <= bus.rw_n;
        end
        H_WAIT: if (dev_ack || dev_err) begin
          st_reg             <= H_ACK;
          reg_rdata          <= bus.data;
          reg_err            <= dev_err;
          bus.transfer_ack_n <= dev_err;
        end
        H_ACK: begin
          st_reg              <= H_IDLE;
          bus.transfer_ack_n  <= HBS_PIN_IDLE;
          bus.chip_select_n   <= HBS_PIN_IDLE;
          bus.host_data_oe_n  <= HBS_PIN_IDLE;
          cmd_busy            <= 1'b0;
          reg_done            <= 1'b1;
          bus.bus_busy_host_n <= HBS_PIN_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== testbench/hbs_chk.sv
// Purpose: concurrent checks on the processor bus between the two ends
// Assumes: one clock, synchronous active-high reset, active-low pins
// Notes:   watches only the interface wires, never the user sides
`timescale 1ns/1ps
module hbs_chk (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // slave cycle
  input wire logic transfer_start_n,
  input wire logic chip_select_n,
  input wire logic transfer_ack_n,
  input wire logic burst_inhibit_n,
  input wire logic slave_ack_n,
  input wire logic transfer_error_ack_n,
  input wire logic dev_data_oe_n,
  // arbitration
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic bus_busy_n,
  input wire logic master_n,
  input wire logic fetch_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // idle take: inhibit still high, so a held start is not seen twice
  sequence s_take;
    !transfer_start_n && !chip_select_n && burst_inhibit_n;
  endsequence
  sequence s_waits;
    (slave_ack_n && transfer_error_ack_n) [*3] ##1 (!slave_ack_n || !transfer_error_ack_n);
  endsequence
  sequence s_close;
    slave_ack_n ##1 (burst_inhibit_n && dev_data_oe_n);
  endsequence
  chk_inhibit_after_take: assert property (s_take |=> !burst_inhibit_n)
    else $error("burst inhibit missing after take");
  chk_three_waits: assert property (s_take |=> s_waits)
    else $error("acknowledge not after three waits");
  chk_one_ack_kind: assert property (!(!slave_ack_n && !transfer_error_ack_n))
    else $error("both acknowledges low");
  chk_error_one_cycle: assert property (!transfer_error_ack_n |=> transfer_error_ack_n)
    else $error("error acknowledge held too long");
  chk_ack_until_ta: assert property (!slave_ack_n && transfer_ack_n |=> !slave_ack_n)
    else $error("slave acknowledge dropped before transfer acknowledge");
  chk_ack_close: assert property (!slave_ack_n && !transfer_ack_n |=> s_close)
    else $error("slave cycle not closed after transfer acknowledge");
  chk_data_in_cycle: assert property (!dev_data_oe_n |-> !burst_inhibit_n)
    else $error("data driven outside a slave cycle");
  chk_grant_own: assert property (!bus_request_n && !bus_grant_n && bus_busy_n
    |=> bus_request_n && (master_n == bus_busy_n))
    else $error("grant not answered next clock");
  chk_fetch_to_req: assert property ($fell(fetch_n) |-> ##[1:2] !bus_request_n)
    else $error("request not 1 to 2 clocks after fetch");
  chk_fetch_after_busy: assert property ($rose(fetch_n) |->
    $past(bus_busy_n) && !($past(bus_busy_n, 2) && $past(bus_busy_n, 3)))
    else $error("fetch released off the busy window");
  chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0) reset |=>
    bus_request_n && bus_busy_n && master_n && slave_ack_n && transfer_error_ack_n)
    else $error("outputs active after reset");
endmodule

// ===== testbench/tb_host_bus_slave_and_arbitration.sv
// Purpose: both ends joined; table of register cycles, then arbitration cases
// Assumes: the bench answers register reads from the access address
// Notes:   one place ends the run; a hang is cut by a cycle ceiling
`timescale 1ns/1ps
module tb_host_bus_slave_and_arbitration;
  import hbs_pkg::*;
  typedef struct packed {
    logic                  wr;
    logic [HBS_ADDR_W-1:0] addr;
    logic [HBS_SIZE_W-1:0] size;
    logic [HBS_DATA_W-1:0] wdata;
    logic                  err;
  } hbs_row_t;
  // bench choice of a faulting register place and of the read pattern
  localparam logic [HBS_ADDR_W-1:0] ERR_ADDR = 7'h7f;
  localparam logic [HBS_DATA_W-1:0] RD_BASE  = 32'ha500_0000;
  logic                  clock, reset, clk_en, cmd_valid, cmd_write, snoop;
  logic [HBS_ADDR_W-1:0] cmd_addr, reg_addr, cap_addr;
  logic [HBS_SIZE_W-1:0] cmd_size, reg_size, cap_size;
  logic [HBS_DATA_W-1:0] cmd_wdata, reg_wdata, cap_wdata, h_rdata, d_rdata;
  logic                  cmd_busy, reg_done, reg_err, reg_access, reg_write, cap_wr, reg_error;
  logic                  need_bus, need_fetch, fetch_retry, master_done, scsi_irq;
  logic                  fast_arb, snoop_mode, owner, irq;
  int                    n_fail, samples_checked, cycle_count, n;
  hbs_row_t              rows [5] = '{
    '{1'b0, 7'h00, 2'h0, 32'h0, 1'b0},
    '{1'b1, 7'h15, 2'h2, 32'hdead_beef, 1'b0},
    '{1'b0, 7'h15, 2'h1, 32'h0, 1'b0},
    '{1'b0, ERR_ADDR, 2'h3, 32'h0, 1'b1},
    '{1'b1, ERR_ADDR, 2'h0, 32'h1234_5678, 1'b1}};
  hbs_if bus_if ();
  hbs_device i_hbs_device (.clock(clock), .reset(reset), .clk_en(clk_en), .bus(bus_if),
    .reg_access(reg_access), .reg_write(reg_write), .reg_addr(reg_addr), .reg_size(reg_size),
    .reg_wdata(reg_wdata), .reg_rdata(d_rdata), .reg_error(reg_error), .need_bus(need_bus),
    .need_fetch(need_fetch), .fetch_retry(fetch_retry), .master_done(master_done),
    .scsi_irq(scsi_irq), .fast_arb(fast_arb), .snoop_mode(snoop_mode), .owner(owner), .irq(irq));
  hbs_host i_hbs_host (.clock(clock), .reset(reset), .clk_en(clk_en), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_size(cmd_size),
    .cmd_wdata(cmd_wdata), .snoop(snoop), .cmd_busy(cmd_busy), .reg_done(reg_done),
    .reg_err(reg_err), .reg_rdata(h_rdata));
  hbs_chk i_hbs_chk (.clock(clock), .reset(reset), .transfer_start_n(bus_if.transfer_start_n),
    .chip_select_n(bus_if.chip_select_n), .transfer_ack_n(bus_if.transfer_ack_n),
    .burst_inhibit_n(bus_if.burst_inhibit_n), .slave_ack_n(bus_if.slave_ack_n),
    .transfer_error_ack_n(bus_if.transfer_error_ack_n), .dev_data_oe_n(bus_if.dev_data_oe_n),
    .bus_request_n(bus_if.bus_request_n), .bus_grant_n(bus_if.bus_grant_n),
    .bus_busy_n(bus_if.bus_busy_n), .master_n(bus_if.master_n), .fetch_n(bus_if.fetch_n));
  assign d_rdata   = RD_BASE | {{(HBS_DATA_W - HBS_ADDR_W){1'b0}}, reg_addr};
  assign reg_error = (reg_addr == ERR_ADDR);
  always @(posedge clock) begin
    if (reg_access === 1'b1) begin
      {cap_wr, cap_size, cap_addr, cap_wdata} <= {reg_write, reg_size, reg_addr, reg_wdata};
    end
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic check(input logic [HBS_DATA_W-1:0] got, input logic [HBS_DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wait_for(ref logic sig, input logic lvl);
    n = 0;
    while (sig !== lvl && n < 30) begin
      tick(1);
      n++;
    end
  endtask
  task automatic host_op(input hbs_row_t r);
    wait_for(cmd_busy, 1'b0);
    {cmd_write, cmd_size, cmd_addr, cmd_wdata} = {r.wr, r.size, r.addr, r.wdata};
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    check(cmd_busy, 1'b1);
    wait_for(reg_done, 1'b1);
    check(reg_err, r.err);
    check({cap_wr, cap_size, cap_addr}, {r.wr, r.size, r.addr});
    if (r.wr) check(cap_wdata, r.wdata);
    if (!r.wr && !r.err) check(h_rdata, RD_BASE | r.addr);
  endtask
  // ownership, then release; retry keeps the fetch indicator low
  task automatic arb(input logic fast, input logic fetch, input logic retry);
    {fast_arb, need_fetch, need_bus} = {fast, fetch, 1'b1};
    wait_for(owner, 1'b1);
    check({bus_if.master_n, bus_if.bus_busy_n, bus_if.bus_request_n}, 3'h1);
    check(bus_if.fetch_n, !fetch);
    {fetch_retry, master_done, need_bus} = {retry, 1'b1, 1'b0};
    tick(1);
    {fetch_retry, master_done} = 2'h0;
    tick(4);
    check(bus_if.master_n, 1'b1);
    check(bus_if.fetch_n, !(fetch && retry));
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {reset, clk_en, cmd_valid, cmd_write, snoop, need_bus, need_fetch} = 7'h60;
    {fetch_retry, master_done, scsi_irq, fast_arb, snoop_mode} = 5'h0;
    {cmd_addr, cmd_size, cmd_wdata} = '0;
    tick(3);
    reset = 1'b0;
    foreach (rows[i]) host_op(rows[i]);
    arb(1'b0, 1'b1, 1'b0);
    arb(1'b0, 1'b1, 1'b1);
    arb(1'b1, 1'b1, 1'b0);
    // busy held by the host's own cycle: only fast mode may take the bus early
    for (int f = 1; f >= 0; f--) begin
      fast_arb = f[0];
      {need_fetch, need_bus, cmd_valid, cmd_write} = 4'h6;
      cmd_addr = 7'h15;
      tick(1);
      cmd_valid = 1'b0;
      tick(3);
      check(owner, fast_arb);
      wait_for(reg_done, 1'b1);
      wait_for(owner, 1'b1);
      check(owner, 1'b1);
      {need_bus, master_done} = 2'h1;
      tick(1);
      master_done = 1'b0;
      tick(3);
    end
    // interrupt while requesting: grant still awaited, then all dropped
    {scsi_irq, need_bus} = 2'h3;
    wait_for(irq, 1'b1);
    check(irq, 1'b1);
    {scsi_irq, need_bus} = 2'h0;
    tick(1);
    check({bus_if.master_n, bus_if.bus_request_n}, 2'h3);
    // snoop mode: request follows snoop control within two clocks
    {snoop_mode, snoop, need_bus} = 3'h6;
    wait_for(bus_if.snoop_ctl0, 1'b1);
    wait_for(bus_if.bus_request_n, 1'b0);
    check(n >= 1 && n <= 2, 1'b1);
    wait_for(owner, 1'b1);
    {snoop, need_bus, master_done} = 3'h1;
    tick(1);
    master_done = 1'b0;
    // frozen clock enable: a pending need must not reach the pins
    {clk_en, need_bus} = 2'h1;
    tick(3);
    check({bus_if.bus_request_n, bus_if.master_n, owner}, 3'h6);
    clk_en = 1'b1;
    // reset in mid-ownership
    wait_for(owner, 1'b1);
    reset = 1'b1;
    tick(1);
    {reset, need_bus} = 2'h0;
    check({bus_if.bus_request_n, bus_if.bus_busy_n, bus_if.master_n}, 3'h7);
    host_op(rows[1]);
    stop_test();
  end
endmodule
